// file: lbb_cfg.svh
`ifndef LBB_CFG_SVH
`define LBB_CFG_SVH

// Control word field positions
`define LBB_CTL_CLK_EN_BIT 0
`define LBB_CTL_ARB_EN_BIT 1
`define LBB_CTL_RDY_LSB 2
`define LBB_CTL_RDY_MSB 5
`define LBB_CTL_WIDTH_BIT 6
`define LBB_CTL_HOLD_LSB 8
`define LBB_CTL_HOLD_MSB 11
`define LBB_CTL_RESET 16'h0000

// Mode strap and bus width codes
`define LBB_MODE_BRIDGE 1'b0
`define LBB_WIDTH_8 1'b1

// Transaction length codes
`define LBB_RDY_USE_PIN 4'h0
`define LBB_RDY_MAX_CODE 4'hb

// Timing counts in local clock periods
`define LBB_RDY_TIMEOUT_LOCAL_BUS_CLOCK 4'h9
`define LBB_HOLD_BASE_LOCAL_BUS_CLOCK 32
`define LBB_HOLD_MARGIN_LOCAL_BUS_CLOCK 21'h000010

// Window decode
`define LBB_BASE_LSB 20
`define LBB_CFG_ADDR_W 16

`endif

// file: lbb_pkg.sv
package lbb_pkg;

  typedef enum logic [1:0] {LBB_LANE_NONE, LBB_LANE_ABORT, LBB_LANE_OK} lbb_lane_kind_type;

  typedef struct packed {
    lbb_lane_kind_type kind;
    logic word;
    logic [1:0] addr_low;
    logic upper_byte_strobe_n;
  } lbb_lane_type;

  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [3:0] pci_byte_enables_n;
    logic [31:0] wdata;
  } lbb_host_req_type;

  typedef struct packed {
    logic done;
    logic target_abort;
    logic target_retry;
    logic [31:0] rdata;
  } lbb_host_resp_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } lbb_cfg_req_type;

  typedef enum logic [1:0] {LBB_IDLE, LBB_CYCLE, LBB_FINISH} lbb_state_type;

  typedef enum logic [1:0] {LBB_ARB_IDLE, LBB_ARB_REQ, LBB_ARB_OWN} lbb_arb_state_type;

endpackage : lbb_pkg

// file: lbb_lane_map.sv
`timescale 1ns/1ps
`include "lbb_cfg.svh"

module lbb_lane_map (
  // Byte enables from the host, active low
  input wire logic [3:0] pci_byte_enables_n,
  input wire logic bus_width_select,
  // Decoded lane
  output lbb_pkg::lbb_lane_type lane
);

  function automatic lbb_pkg::lbb_lane_type decode(input logic [3:0] be_n, input logic width8);
    lbb_pkg::lbb_lane_type r;
    r.kind = lbb_pkg::LBB_LANE_OK;
    r.word = 1'b0;
    r.addr_low = 2'h0;
    case (be_n)
      4'hf: r.kind = lbb_pkg::LBB_LANE_NONE;
      4'he: r.addr_low = 2'h0;
      4'hd: r.addr_low = 2'h1;
      4'hb: r.addr_low = 2'h2;
      4'h7: r.addr_low = 2'h3;
      4'hc: begin
        r.word = 1'b1;
        r.addr_low = 2'h0;
      end
      4'h3: begin
        r.word = 1'b1;
        r.addr_low = 2'h2;
      end
      default: r.kind = lbb_pkg::LBB_LANE_ABORT;
    endcase
    if (width8 && r.word) begin
      r.kind = lbb_pkg::LBB_LANE_ABORT;
    end
    // Upper strobe low only for a word or an odd byte on the 16-bit bus
    r.upper_byte_strobe_n = width8 ? 1'b1 : ~(r.word | r.addr_low[0]);
    return r;
  endfunction : decode

  assign lane = decode(pci_byte_enables_n, bus_width_select == `LBB_WIDTH_8);

endmodule : lbb_lane_map

// file: lbb_arb.sv
`timescale 1ns/1ps
`include "lbb_cfg.svh"

module lbb_arb #(
  parameter int unsigned HOLD_BASE_LOCAL_BUS_CLOCK = `LBB_HOLD_BASE_LOCAL_BUS_CLOCK
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic local_bus_clock_tick,
  input wire logic arbitration_enable,
  input wire logic [3:0] hold_time_select,
  input wire logic access_request,
  input wire logic grant_sync,
  // Status
  output logic hold_request,
  output logic bus_owned,
  output logic access_ok
);

  lbb_pkg::lbb_arb_state_type state_reg;
  logic pending_reg;
  logic [20:0] remain_reg;
  logic [20:0] hold_len;

  assign hold_len = 21'(HOLD_BASE_LOCAL_BUS_CLOCK) << hold_time_select;
  assign access_ok = bus_owned && (remain_reg >= `LBB_HOLD_MARGIN_LOCAL_BUS_CLOCK);

  always_ff @(posedge core_clk) begin
    if (rst || !arbitration_enable) begin
      state_reg <= lbb_pkg::LBB_ARB_IDLE;
      pending_reg <= 1'b0;
      remain_reg <= 21'h000000;
      hold_request <= 1'b0;
      bus_owned <= 1'b0;
    end else begin
      case (state_reg)
        lbb_pkg::LBB_ARB_IDLE: begin
          if (access_request || pending_reg) begin
            state_reg <= lbb_pkg::LBB_ARB_REQ;
            hold_request <= 1'b1;
          end
          pending_reg <= 1'b0;
        end
        lbb_pkg::LBB_ARB_REQ: begin
          if (grant_sync) begin
            state_reg <= lbb_pkg::LBB_ARB_OWN;
            bus_owned <= 1'b1;
            remain_reg <= hold_len;
          end
        end
        lbb_pkg::LBB_ARB_OWN: begin
          pending_reg <= pending_reg || access_request;
          if (local_bus_clock_tick) begin
            remain_reg <= remain_reg - 21'h000001;
            if (remain_reg == 21'h000001) begin
              state_reg <= lbb_pkg::LBB_ARB_IDLE;
              hold_request <= 1'b0;
              bus_owned <= 1'b0;
            end
          end
        end
        default: state_reg <= lbb_pkg::LBB_ARB_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_owned_needs_hold;
    @(posedge core_clk) disable iff (rst) bus_owned |-> hold_request;
  endproperty
  a_owned_needs_hold: assert property (p_owned_needs_hold) else $error("bus owned without hold request");

  property p_hold_load;
    @(posedge core_clk) disable iff (rst)
      (state_reg == lbb_pkg::LBB_ARB_REQ && grant_sync && arbitration_enable) |=> (remain_reg == $past(hold_len));
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("hold timer not loaded on grant");

  property p_margin;
    @(posedge core_clk) disable iff (rst) access_ok |-> (bus_owned && remain_reg >= 21'h000010);
  endproperty
  a_margin: assert property (p_margin) else $error("access allowed with short hold time");

endmodule : lbb_arb

// file: lbb_bridge.sv
// Operation
// - Mode strap low selects bridge master, high selects configuration slave.
// - Bridge mode drives all local address, data and strobes for host accesses.
// - Twenty address lines give a 1M byte window placed by the base address.
// - Width bit zero gives 16-bit data, one gives 8-bit data.
// - 8-bit width: patterns e,d,b,7 give address 0..3, upper strobe high.
// - 8-bit width: any other enable pattern except f gets a target abort.
// - No byte enables: no abort and no local cycle.
// - 16-bit width: patterns c and 3 give word cycles at 0 and 2.
// - 16-bit single bytes: even lane low byte with strobe high, odd lane high byte with strobe low.
// - 16-bit width: unsupported patterns get a target abort.
// - Arbitration off by default; when on, request then wait for grant.
// - Access while bus not owned gets retry, pins stay tri-stated.
// - Retried access still requests bus; ownership lasts the programmed period.
// - Hold field picks 32 doubling to 1048576 local clocks from grant.
// - Access proceeds only with grant and at least 16 clocks remaining.
// - Each cycle ends on external ready or after 1 to 11 local clocks.
// - Ready field: 0 pin, 1..11 fixed length, 12..15 illegal; the code treats 12..15 like 0 and waits for the ready pin.
// - No ready within 9 local clocks: retry and set error flag.
// - External interrupt sets a sticky flag driving masked PCI interrupt; the code ignores it in configuration mode.
// - Configuration mode serves external processor and ignores config select.
// - Configuration mode forwards no data between local bus and PCI.
// - Configuration mode disables arbitration, width and transaction length.
// - Configuration mode uses 16-bit address and data, upper four lines ignored.
`timescale 1ns/1ps
`include "lbb_cfg.svh"

module lbb_bridge #(
  parameter int unsigned HOLD_BASE_LOCAL_BUS_CLOCK = `LBB_HOLD_BASE_LOCAL_BUS_CLOCK
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Strap and control
  input wire logic mode_select_pin,
  input wire logic [15:0] bridge_control_reg,
  input wire logic [11:0] base_address_hi,
  input wire logic irq_mask_reg,
  input wire logic local_irq_clear,
  input wire logic local_error_clear,
  input wire logic config_select_in,
  // Host request and answer
  input wire logic host_req_valid,
  input wire lbb_pkg::lbb_host_req_type host_req,
  output lbb_pkg::lbb_host_resp_type host_resp,
  // Local bus outputs
  output logic local_bus_clock,
  output logic local_bus_clock_oe,
  output logic [19:0] local_address_lines,
  output logic local_address_oe,
  output logic [15:0] local_data_out,
  output logic local_data_oe,
  output logic upper_byte_strobe_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic strobe_oe,
  // Local bus inputs
  input wire logic [15:0] local_data_in,
  input wire logic [19:0] local_address_in,
  input wire logic write_strobe_in_n,
  input wire logic read_strobe_in_n,
  input wire logic chip_select_in_n,
  input wire logic transfer_ready_in_n,
  // Arbitration
  input wire logic hold_grant_in,
  output logic hold_request_out,
  output logic bus_owned_ack_n,
  output logic arb_pins_oe,
  // Interrupt and status
  input wire logic external_irq_in_n,
  output logic local_irq_flag,
  output logic local_error_flag,
  output logic pci_irq_out_n,
  output logic config_select_gated,
  // Configuration port
  output lbb_pkg::lbb_cfg_req_type cfg_req,
  input wire logic [15:0] cfg_rdata
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int SYNC_W = 43;
  logic [SYNC_W-1:0] pin_vec;
  logic [SYNC_W-1:0] pin_sync1_reg;
  logic [SYNC_W-1:0] pin_sync2_reg;
  logic mode_s, ready_n_s, grant_s, irq_n_s, wr_in_n_s, rd_in_n_s, cs_n_s;
  logic [15:0] data_s;
  logic [19:0] addr_s;

  assign pin_vec = {mode_select_pin, transfer_ready_in_n, hold_grant_in, external_irq_in_n, local_data_in,
                    local_address_in, write_strobe_in_n, read_strobe_in_n, chip_select_in_n};

  always_ff @(posedge core_clk) begin
    pin_sync1_reg <= pin_vec;
    pin_sync2_reg <= pin_sync1_reg;
  end

  assign {mode_s, ready_n_s, grant_s, irq_n_s, data_s, addr_s, wr_in_n_s, rd_in_n_s, cs_n_s} = pin_sync2_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode and control decode
  logic bridge_mode, arb_en, width8, clk_en, fixed_len;
  logic [3:0] rdy_code, hold_code;

  assign bridge_mode = (mode_s == `LBB_MODE_BRIDGE);
  assign arb_en = bridge_mode & bridge_control_reg[`LBB_CTL_ARB_EN_BIT];
  assign width8 = bridge_mode & bridge_control_reg[`LBB_CTL_WIDTH_BIT];
  assign clk_en = bridge_mode & bridge_control_reg[`LBB_CTL_CLK_EN_BIT];
  assign rdy_code = bridge_control_reg[`LBB_CTL_RDY_MSB:`LBB_CTL_RDY_LSB];
  assign hold_code = bridge_control_reg[`LBB_CTL_HOLD_MSB:`LBB_CTL_HOLD_LSB];
  assign fixed_len = (rdy_code != `LBB_RDY_USE_PIN) && (rdy_code <= `LBB_RDY_MAX_CODE);

  ////////////////////////////////////////////////////////////////////////////////
  // Local clock, half the core rate; tick marks a rising edge
  logic local_bus_clock_reg;
  logic local_bus_clock_tick;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      local_bus_clock_reg <= 1'b0;
    end else begin
      local_bus_clock_reg <= ~local_bus_clock_reg;
    end
  end

  assign local_bus_clock_tick = ~local_bus_clock_reg;
  assign local_bus_clock = local_bus_clock_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Lane decode and arbitration
  lbb_pkg::lbb_lane_type lane;
  logic hit, arb_req, arb_ok, arb_hold, arb_owned, go, lane_ok;

  lbb_lane_map u_lane (
    .pci_byte_enables_n(host_req.pci_byte_enables_n),
    .bus_width_select(width8),
    .lane(lane)
  );

  lbb_pkg::lbb_state_type state_reg, state_next;
  logic idle;

  assign idle = (state_reg == lbb_pkg::LBB_IDLE);
  assign hit = idle && host_req_valid && bridge_mode &&
               (host_req.addr[31:`LBB_BASE_LSB] == base_address_hi);
  assign lane_ok = (lane.kind == lbb_pkg::LBB_LANE_OK);
  assign arb_req = hit && lane_ok && arb_en && !arb_ok;
  assign go = hit && lane_ok && (!arb_en || arb_ok);

  lbb_arb #(.HOLD_BASE_LOCAL_BUS_CLOCK(HOLD_BASE_LOCAL_BUS_CLOCK)) u_arb (
    .core_clk(core_clk),
    .rst(rst),
    .local_bus_clock_tick(local_bus_clock_tick),
    .arbitration_enable(arb_en),
    .hold_time_select(hold_code),
    .access_request(arb_req),
    .grant_sync(grant_s),
    .hold_request(arb_hold),
    .bus_owned(arb_owned),
    .access_ok(arb_ok)
  );

  assign hold_request_out = arb_hold;

  ////////////////////////////////////////////////////////////////////////////////
  // Bridge cycle sequencer
  logic [3:0] cnt_reg, cnt_next;
  logic cur_write_reg, word_reg;
  logic ready_seen, len_done, timeout;
  logic [15:0] wr_data;

  // Word takes its half; odd byte rides the high lines on the 16-bit bus only
  assign wr_data = lane.word ? host_req.wdata[16*lane.addr_low[1] +: 16] :
                   (!width8 && lane.addr_low[0]) ? {host_req.wdata[8*lane.addr_low +: 8], 8'h00} :
                   {8'h00, host_req.wdata[8*lane.addr_low +: 8]};
  assign ready_seen = !fixed_len && !ready_n_s;
  assign len_done = fixed_len && (cnt_reg + 4'h1 == rdy_code);
  assign timeout = !fixed_len && ready_n_s && (cnt_reg + 4'h1 == `LBB_RDY_TIMEOUT_LOCAL_BUS_CLOCK);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      lbb_pkg::LBB_IDLE: begin
        cnt_next = 4'h0;
        if (go) begin
          state_next = lbb_pkg::LBB_CYCLE;
        end
      end
      lbb_pkg::LBB_CYCLE: begin
        if (local_bus_clock_tick) begin
          cnt_next = cnt_reg + 4'h1;
          if (ready_seen || len_done || timeout) begin
            state_next = lbb_pkg::LBB_FINISH;
          end
        end
      end
      lbb_pkg::LBB_FINISH: state_next = lbb_pkg::LBB_IDLE;
      default: state_next = lbb_pkg::LBB_IDLE;
    endcase
  end

  logic cycle_end;
  assign cycle_end = (state_reg == lbb_pkg::LBB_CYCLE) && local_bus_clock_tick && (ready_seen || len_done || timeout);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= lbb_pkg::LBB_IDLE;
      cnt_reg <= 4'h0;
      cur_write_reg <= 1'b0;
      word_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (go) begin
        cur_write_reg <= host_req.write;
        word_reg <= lane.word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Local pin drivers
  logic cfg_read_drive;
  assign cfg_read_drive = !bridge_mode && !cs_n_s && !rd_in_n_s;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      local_address_lines <= 20'h00000;
      local_address_oe <= 1'b0;
      local_data_out <= 16'h0000;
      local_data_oe <= 1'b0;
      upper_byte_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      strobe_oe <= 1'b0;
      arb_pins_oe <= 1'b0;
      local_bus_clock_oe <= 1'b0;
      bus_owned_ack_n <= 1'b1;
    end else begin
      arb_pins_oe <= arb_en;
      bus_owned_ack_n <= ~arb_owned;
      local_bus_clock_oe <= clk_en;
      strobe_oe <= bridge_mode && (!arb_en || arb_owned);
      if (go) begin
        local_address_lines <= {host_req.addr[19:2], lane.addr_low};
        local_address_oe <= 1'b1;
        local_data_out <= wr_data;
        local_data_oe <= host_req.write;
        upper_byte_strobe_n <= lane.upper_byte_strobe_n;
        write_strobe_n <= ~host_req.write;
        read_strobe_n <= host_req.write;
      end else if (cycle_end) begin
        write_strobe_n <= 1'b1;
        read_strobe_n <= 1'b1;
      end else if (state_reg != lbb_pkg::LBB_CYCLE) begin
        local_address_oe <= 1'b0;
        upper_byte_strobe_n <= 1'b1;
        local_data_oe <= cfg_read_drive;
        local_data_out <= cfg_read_drive ? cfg_rdata : local_data_out;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host answer and status flags
  logic [31:0] rd_data;
  logic irq_prev_reg;
  logic irq_fall;

  assign rd_data = (width8 || !word_reg) ? {4{data_s[7:0] | data_s[15:8]}} : {2{data_s}};
  assign irq_fall = irq_prev_reg && !irq_n_s && bridge_mode;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      host_resp <= '0;
      local_error_flag <= 1'b0;
      local_irq_flag <= 1'b0;
      irq_prev_reg <= 1'b1;
      pci_irq_out_n <= 1'b1;
      config_select_gated <= 1'b0;
    end else begin
      host_resp.done <= (hit && !go) || cycle_end;
      host_resp.target_abort <= hit && (lane.kind == lbb_pkg::LBB_LANE_ABORT);
      host_resp.target_retry <= arb_req || (cycle_end && timeout);
      if (cycle_end && !cur_write_reg) begin
        host_resp.rdata <= rd_data;
      end
      local_error_flag <= (cycle_end && timeout) || (local_error_flag && !local_error_clear);
      irq_prev_reg <= irq_n_s;
      local_irq_flag <= irq_fall || (local_irq_flag && !local_irq_clear);
      pci_irq_out_n <= ~(local_irq_flag && !irq_mask_reg);
      config_select_gated <= config_select_in && bridge_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration slave port
  logic wr_prev_reg, rd_prev_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_prev_reg <= 1'b1;
      rd_prev_reg <= 1'b1;
      cfg_req <= '0;
    end else begin
      wr_prev_reg <= wr_in_n_s;
      rd_prev_reg <= rd_in_n_s;
      cfg_req.valid <= !bridge_mode && !cs_n_s && ((wr_prev_reg && !wr_in_n_s) || (rd_prev_reg && !rd_in_n_s));
      cfg_req.write <= !wr_in_n_s;
      cfg_req.addr <= addr_s[`LBB_CFG_ADDR_W-1:0];
      cfg_req.wdata <= data_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_abort;
    @(posedge core_clk) disable iff (rst)
      (hit && lane.kind == lbb_pkg::LBB_LANE_ABORT) |=> (host_resp.target_abort && host_resp.done && !local_address_oe);
  endproperty
  a_abort: assert property (p_abort) else $error("bad byte enables not aborted");

  property p_none;
    @(posedge core_clk) disable iff (rst)
      (hit && lane.kind == lbb_pkg::LBB_LANE_NONE) |=> (host_resp.done && !host_resp.target_abort && !local_address_oe);
  endproperty
  a_none: assert property (p_none) else $error("empty byte enables misbehaved");

  property p_retry_tristate;
    @(posedge core_clk) disable iff (rst) arb_req |=> (host_resp.target_retry && !local_address_oe && !local_data_oe);
  endproperty
  a_retry_tristate: assert property (p_retry_tristate) else $error("unowned access not retried");

  property p_byte8;
    @(posedge core_clk) disable iff (rst) (go && width8) |=> (upper_byte_strobe_n && local_data_out[15:8] == 8'h00);
  endproperty
  a_byte8: assert property (p_byte8) else $error("8-bit cycle used upper lane");

  property p_word16;
    @(posedge core_clk) disable iff (rst)
      (go && !width8 && lane.word) |=> (!upper_byte_strobe_n && local_address_lines[0] == 1'b0);
  endproperty
  a_word16: assert property (p_word16) else $error("word cycle strobes wrong");

  sequence s_ready_miss;
    (state_reg == lbb_pkg::LBB_CYCLE && local_bus_clock_tick && !fixed_len && ready_n_s && cnt_reg == 4'h8);
  endsequence

  property p_timeout;
    @(posedge core_clk) disable iff (rst) s_ready_miss |=> (local_error_flag && host_resp.target_retry) ##1 idle;
  endproperty
  a_timeout: assert property (p_timeout) else $error("ready timeout not flagged");

  property p_fixed_len;
    @(posedge core_clk) disable iff (rst) (state_reg == lbb_pkg::LBB_CYCLE && fixed_len) |-> (cnt_reg < rdy_code);
  endproperty
  a_fixed_len: assert property (p_fixed_len) else $error("fixed cycle overran");

  property p_irq;
    @(posedge core_clk) disable iff (rst) irq_fall |=> local_irq_flag ##1 (pci_irq_out_n == irq_mask_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt flag not raised");

  sequence s_cfg_write;
    (!bridge_mode && !cs_n_s && wr_prev_reg && !wr_in_n_s);
  endsequence

  property p_cfg_write;
    @(posedge core_clk) disable iff (rst)
      s_cfg_write |=> (cfg_req.valid && cfg_req.write && cfg_req.addr == $past(addr_s[15:0]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write not passed on");

  property p_cfg_no_bridge;
    @(posedge core_clk) disable iff (rst) (!bridge_mode && idle) |=> !local_address_oe;
  endproperty
  a_cfg_no_bridge: assert property (p_cfg_no_bridge) else $error("bridge cycle in config mode");

endmodule : lbb_bridge

// file: lbb_periph_model.sv
`timescale 1ns/1ps

module lbb_periph_model (
  // Clock
  input wire logic core_clk,
  // Cycle from the bridge
  input wire logic [19:0] local_address_lines,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic strobe_oe,
  // Answer delay in core clocks, zero never answers
  input wire logic [4:0] ready_delay,
  // Answer to the bridge
  output logic [15:0] local_data_in,
  output logic transfer_ready_in_n
);
  logic [4:0] wait_reg = 5'h00;
  logic [15:0] last_reg = 16'h0000;
  wire active = strobe_oe && !(read_strobe_n && write_strobe_n);
  initial begin
    local_data_in = 16'hffff;
    transfer_ready_in_n = 1'b1;
  end
  always @(posedge core_clk) begin
    wait_reg <= active ? wait_reg + 5'h01 : 5'h00;
    transfer_ready_in_n <= !(active && ready_delay != 5'h00 && wait_reg >= ready_delay);
    // Released data lines show the inverse so a stale value cannot pass
    if (active && !read_strobe_n) begin
      last_reg = local_address_lines[15:0] ^ 16'hc3c3;
      local_data_in <= last_reg;
    end else
      local_data_in <= ~last_reg;
  end
endmodule : lbb_periph_model

// file: testbench.sv
`timescale 1ns/1ps

module testbench;
  logic core_clk = 1'b0, rst = 1'b1, mode_select_pin = 1'b0, host_req_valid = 1'b0, irq_mask_reg = 1'b0;
  logic local_irq_clear = 1'b0, local_error_clear = 1'b0, write_strobe_in_n = 1'b1, chip_select_in_n = 1'b1;
  logic hold_grant_in = 1'b0, external_irq_in_n = 1'b1;
  logic [15:0] ctl = 16'h0000;
  logic [19:0] local_address_in = 20'h00000;
  logic [4:0] ready_delay = 5'h03;
  lbb_pkg::lbb_host_req_type host_req = '0;
  lbb_pkg::lbb_host_resp_type host_resp;
  lbb_pkg::lbb_cfg_req_type cfg_req;
  logic [19:0] local_address_lines, s_addr;
  logic [15:0] local_data_out, local_data_in, s_data;
  logic upper_byte_strobe_n, write_strobe_n, read_strobe_n, strobe_oe, transfer_ready_in_n, s_ube;
  logic hold_request_out, bus_owned_ack_n, local_irq_flag, local_error_flag, pci_irq_out_n;
  logic seen, done, abrt, rtry;
  int num_errors = 0, cmp_count = 0, low_cnt;
  logic [18:0] exp16[4] = '{{1'b0, 2'd0, 16'h2211}, {1'b0, 2'd2, 16'h4433}, {1'b0, 2'd1, 16'h2200}, {1'b1, 2'd2, 16'h0033}};
  logic [15:0] msk16[4] = '{16'hffff, 16'hffff, 16'hff00, 16'h00ff};
  logic [3:0] be16[4] = '{4'hc, 4'h3, 4'hd, 4'hb};
  logic [4:0] bad[5] = '{5'h1c, 5'h15, 5'h05, 5'h09, 5'h08};
  always #2 core_clk = ~core_clk;

  lbb_bridge #(.HOLD_BASE_LOCAL_BUS_CLOCK(1)) u_lbb_bridge (.core_clk(core_clk), .rst(rst), .mode_select_pin(mode_select_pin),
    .bridge_control_reg(ctl), .base_address_hi(12'h0a5), .irq_mask_reg(irq_mask_reg), .local_irq_clear(local_irq_clear),
    .local_error_clear(local_error_clear), .config_select_in(1'b0), .host_req_valid(host_req_valid),
    .host_req(host_req), .host_resp(host_resp), .local_bus_clock(), .local_bus_clock_oe(),
    .local_address_lines(local_address_lines), .local_address_oe(), .local_data_out(local_data_out),
    .local_data_oe(), .upper_byte_strobe_n(upper_byte_strobe_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .strobe_oe(strobe_oe), .local_data_in(local_data_in),
    .local_address_in(local_address_in), .write_strobe_in_n(write_strobe_in_n), .read_strobe_in_n(1'b1),
    .chip_select_in_n(chip_select_in_n), .transfer_ready_in_n(transfer_ready_in_n), .hold_grant_in(hold_grant_in),
    .hold_request_out(hold_request_out), .bus_owned_ack_n(bus_owned_ack_n), .arb_pins_oe(),
    .external_irq_in_n(external_irq_in_n), .local_irq_flag(local_irq_flag), .local_error_flag(local_error_flag),
    .pci_irq_out_n(pci_irq_out_n), .config_select_gated(), .cfg_req(cfg_req), .cfg_rdata(16'h0000));

  lbb_periph_model u_lbb_periph_model (.core_clk(core_clk), .local_address_lines(local_address_lines),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .strobe_oe(strobe_oe),
    .ready_delay(ready_delay), .local_data_in(local_data_in), .transfer_ready_in_n(transfer_ready_in_n));

  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One host access; records the local cycle and the answer
  task automatic acc(input logic w, input logic [3:0] be);
    @(negedge core_clk);
    host_req_valid = 1'b1;
    host_req = '{w, 32'h0a512340, be, 32'h44332211};
    {seen, done, abrt, rtry} = 4'h0;
    low_cnt = 0;
    @(negedge core_clk);
    host_req_valid = 1'b0;
    for (int i = 0; i < 80 && !done; i++) begin
      if (strobe_oe === 1'b1 && (write_strobe_n === 1'b0 || read_strobe_n === 1'b0)) begin
        seen = 1'b1;
        low_cnt++;
        {s_addr, s_data, s_ube} = {local_address_lines, local_data_out, upper_byte_strobe_n};
      end
      if (host_resp.done === 1'b1) begin
        {done, abrt, rtry} = {1'b1, host_resp.target_abort, host_resp.target_retry};
      end
      @(negedge core_clk);
    end
  endtask : acc

  ////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("reset", 32'hb, {strobe_oe, hold_request_out, bus_owned_ack_n, pci_irq_out_n});
    ctl = 16'h0044;
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, ~(4'h1 << k));
      chk("lane8", {2'b01, 2'(k), 8'h11 * 8'(k + 1)}, {abrt, s_ube, s_addr[1:0], s_data[7:0]});
      chk("addr", 32'h12340 + k, 32'(s_addr));
    end
    ctl = 16'h0004;
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, be16[k]);
      chk("lane16", 32'(exp16[k]), 32'({s_ube, s_addr[1:0], s_data & msk16[k]}));
    end
    ctl = 16'h000c;
    acc(1'b0, 4'hc);
    chk("rdata", 32'he083, 32'(host_resp.rdata[15:0]));
    for (int k = 0; k < 5; k++) begin
      ctl[6] = bad[k][4];
      acc(1'b1, bad[k][3:0]);
      chk("abort", 32'h6, {done, abrt, seen});
      acc(1'b1, 4'hf);
      chk("no lanes", 32'h0, {abrt, seen});
    end
    ctl = 16'h0000;
    acc(1'b1, 4'hc);
    chk("ready pin", 32'h4, {done, rtry, local_error_flag});
    ready_delay = 5'h00;
    acc(1'b1, 4'hc);
    @(negedge core_clk);
    chk("timeout", 32'h7, {done, rtry, local_error_flag});
    local_error_clear = 1'b1;
    @(negedge core_clk);
    local_error_clear = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("error clear", 32'h0, 32'(local_error_flag));
    for (int n = 1; n <= 11; n += 10) begin
      ctl = 16'(n << 2);
      acc(1'b1, 4'hc);
      chk("length", 32'h1, 32'(done && !rtry && low_cnt >= 2 * n - 1 && low_cnt <= 2 * n + 1));
    end
    ctl = 16'h0606;
    acc(1'b1, 4'hc);
    chk("unowned", 32'hc, {done, rtry, seen, strobe_oe});
    repeat (4) @(negedge core_clk);
    chk("hold req", 32'h1, 32'(hold_request_out));
    hold_grant_in = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("owned", 32'h0, 32'(bus_owned_ack_n));
    acc(1'b1, 4'hc);
    chk("owned access", 32'h5, {done, rtry, seen});
    hold_grant_in = 1'b0;
    repeat (140) @(negedge core_clk);
    chk("hold end", 32'h1, 32'(bus_owned_ack_n));
    ctl = 16'h0000;
    external_irq_in_n = 1'b0;
    repeat (6) @(negedge core_clk);
    chk("irq", 32'h2, {local_irq_flag, pci_irq_out_n});
    irq_mask_reg = 1'b1;
    {external_irq_in_n, local_irq_clear} = 2'b11;
    repeat (3) @(negedge core_clk);
    chk("irq mask", 32'h1, {local_irq_flag, pci_irq_out_n});
    local_irq_clear = 1'b0;
    mode_select_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    acc(1'b1, 4'hc);
    chk("config host", 32'h0, {done, seen});
    {local_address_in, chip_select_in_n, write_strobe_in_n} = {20'hf1234, 2'b00};
    done = 1'b0;
    for (int i = 0; i < 12 && !done; i++) begin
      @(negedge core_clk);
      if (cfg_req.valid === 1'b1)
        {done, s_addr} = {1'b1, 4'h0, cfg_req.addr};
    end
    chk("cfg write", 32'h11234, {done, s_addr[15:0]});
    {chip_select_in_n, write_strobe_in_n} = 2'b11;
    repeat (4) @(negedge core_clk);
    report_and_stop();
  end
endmodule : testbench
